// ---- core/epaper_waveform_generator.sv ----
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module epaper_waveform_generator
    import epd_wave_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Oscillator levels
    input wire logic fast_osc_a,
    input wire logic fast_osc_b,
    input wire logic slow_osc,
    // Panel electrodes, high level means drive voltage
    output logic [SEG_COUNT-1:0] seg_out,
    output logic [SEG_COUNT-1:0] seg_oe,
    output logic [1:0] bp_out,
    output logic [1:0] bp_oe,
    output logic [1:0] tp_out,
    output logic [1:0] tp_oe,
    // System status
    output logic update_busy,
    output logic update_done_irq,
    output logic update_trigger_out,
    output logic divided_timing_clock
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic aw_full_q;
    logic w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [1:0] tclk_src_q;
    logic [2:0] tclk_div_q;
    logic tclk_gate_q;
    logic direct_q;
    logic done_flag_q;
    logic irq_en_q;
    logic [SEG_COUNT-1:0] seg_data_q;
    logic bp_data_q;
    logic tp_data_q;
    logic seg_hz_q;
    logic tp_hz_q;
    logic [15:0] wave_q [NUM_STEPS];
    play_state_type state_q;
    logic [4:0] step_idx_q;
    logic [7:0] intv_cnt_q;
    logic [SEG_COUNT:0] new_q;
    logic [SEG_COUNT:0] prev_q;
    logic [SEG_COUNT:0] wave_lvl;
    logic [15:0] cur_step;
    logic tick;
    logic busy;
    logic wr_tclk;
    logic wr_panel;
    logic wr_irq;
    logic trig_wr;
    logic trig_ok;
    logic start_wave;
    logic last_step;
    logic step_end;
    logic finish;
    logic trig_out_q;
    logic [31:0] wave_wr_word;

    function automatic logic [31:0] merge_word(input logic [31:0] old,
                                               input logic [31:0] val,
                                               input logic [31:0] mask);
        return (old & ~mask) | (val & mask);
    endfunction : merge_word

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels; address and data may arrive in either order
    assign awready = ~aw_full_q;
    assign wready = ~w_full_q;
    assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end
        end
    end

    // Write decode; unmapped addresses answer with a slave error
    always_comb begin
        wr_hit = 1'b1;
        if (aw_addr_q[7]) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == TCLK_CTRL_OFS[7:2]) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == PANEL_CTRL_OFS[7:2]) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == IRQ_CTRL_OFS[7:2]) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == SEG_LO_OFS[7:2]) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == SEG_HI_OFS[7:2]) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == PLANE_DATA_OFS[7:2]) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    assign wr_tclk = wr_fire && (aw_addr_q[7:2] == TCLK_CTRL_OFS[7:2]);
    assign wr_panel = wr_fire && (aw_addr_q[7:2] == PANEL_CTRL_OFS[7:2]);
    assign wr_irq = wr_fire && (aw_addr_q[7:2] == IRQ_CTRL_OFS[7:2]);

    ////////////////////////////////////////////////////////////////////////
    // Timing clock control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tclk_src_q <= SRC_RST;
            tclk_div_q <= DIV_RST;
            tclk_gate_q <= GATE_RST;
        end else if (wr_tclk) begin
            if (w_strb_q[0]) begin
                tclk_src_q <= w_data_q[SRC_LSB +: 2];
                tclk_div_q <= w_data_q[DIV_LSB +: 3];
            end
            if (w_strb_q[1]) begin
                tclk_gate_q <= w_data_q[GATE_BIT];
            end
        end
    end

    tclk_divider u_tclk_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .fast_osc_a(fast_osc_a),
        .fast_osc_b(fast_osc_b),
        .slow_osc(slow_osc),
        .source_sel(tclk_src_q),
        .divide_sel(tclk_div_q),
        .gate_on(tclk_gate_q),
        .tick(tick)
    );

    assign divided_timing_clock = tick;

    ////////////////////////////////////////////////////////////////////////
    // Mode, trigger and done flag
    assign trig_wr = wr_panel && w_strb_q[0] && w_data_q[TRIG_BIT];
    assign trig_ok = trig_wr && !busy;
    assign start_wave = trig_ok && !direct_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            direct_q <= DIRECT_RST;
        end else if (wr_panel && w_strb_q[0]) begin
            direct_q <= w_data_q[DIRECT_BIT];
        end
    end

    // Set beats a simultaneous write-one-to-clear so no end event is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (finish) begin
                done_flag_q <= 1'b1;
            end else if (wr_irq && w_strb_q[0] && w_data_q[DONE_BIT]) begin
                done_flag_q <= 1'b0;
            end
            if (wr_irq && w_strb_q[1]) begin
                irq_en_q <= w_data_q[IRQEN_BIT];
            end
        end
    end

    assign update_done_irq = done_flag_q & irq_en_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_out_q <= 1'b0;
        end else begin
            trig_out_q <= trig_ok;
        end
    end

    assign update_trigger_out = trig_out_q;

    ////////////////////////////////////////////////////////////////////////
    // Display data and waveform store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seg_data_q <= '0;
            bp_data_q <= 1'b0;
            tp_data_q <= 1'b0;
            seg_hz_q <= 1'b0;
            tp_hz_q <= 1'b0;
        end else if (wr_fire) begin
            if (aw_addr_q[7:2] == SEG_LO_OFS[7:2]) begin
                seg_data_q[31:0] <= merge_word(seg_data_q[31:0], w_data_q, wmask);
            end
            if (aw_addr_q[7:2] == SEG_HI_OFS[7:2]) begin
                seg_data_q[63:32] <= merge_word(seg_data_q[63:32], w_data_q, wmask);
            end
            if ((aw_addr_q[7:2] == PLANE_DATA_OFS[7:2]) && w_strb_q[0]) begin
                bp_data_q <= w_data_q[BP_BIT];
                tp_data_q <= w_data_q[TP_BIT];
                seg_hz_q <= w_data_q[SEGHZ_BIT];
                tp_hz_q <= w_data_q[TPHZ_BIT];
            end
        end
    end

    // Byte-merged image of the addressed timing set; only the low half is kept
    assign wave_wr_word = merge_word({16'h0, wave_q[aw_addr_q[6:2]]}, w_data_q, wmask);

    // One register per timing set; the reserved bit 14 is not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_STEPS; i++) begin
                wave_q[i] <= WAVE_RST;
            end
        end else if (wr_fire && aw_addr_q[7]) begin
            wave_q[aw_addr_q[6:2]] <= wave_wr_word[15:0] & STEP_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, answered one cycle after the address is taken
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        if (araddr[7]) begin
            rd_word[15:0] = wave_q[araddr[6:2]];
        end else if (araddr[7:2] == TCLK_CTRL_OFS[7:2]) begin
            rd_word[SRC_LSB +: 2] = tclk_src_q;
            rd_word[DIV_LSB +: 3] = tclk_div_q;
            rd_word[GATE_BIT] = tclk_gate_q;
        end else if (araddr[7:2] == PANEL_CTRL_OFS[7:2]) begin
            rd_word[BUSY_BIT] = busy;
            rd_word[DIRECT_BIT] = direct_q;
        end else if (araddr[7:2] == IRQ_CTRL_OFS[7:2]) begin
            rd_word[DONE_BIT] = done_flag_q;
            rd_word[IRQEN_BIT] = irq_en_q;
        end else if (araddr[7:2] == SEG_LO_OFS[7:2]) begin
            rd_word = seg_data_q[31:0];
        end else if (araddr[7:2] == SEG_HI_OFS[7:2]) begin
            rd_word = seg_data_q[63:32];
        end else if (araddr[7:2] == PLANE_DATA_OFS[7:2]) begin
            rd_word[BP_BIT] = bp_data_q;
            rd_word[TP_BIT] = tp_data_q;
            rd_word[SEGHZ_BIT] = seg_hz_q;
            rd_word[TPHZ_BIT] = tp_hz_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    assign arready = ~rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Playback sequencer; it stalls if software gates the clock mid-wave
    assign busy = (state_q == ST_PLAY);
    assign update_busy = busy;
    assign cur_step = wave_q[step_idx_q];
    assign last_step = cur_step[EOW_BIT] || (step_idx_q == LAST_STEP);
    assign step_end = busy && tick && (intv_cnt_q == 8'h00);
    assign finish = step_end && last_step;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_wave) begin
                        state_q <= ST_PLAY;
                    end
                end
                ST_PLAY: begin
                    if (finish) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Interval counter reloads at each set boundary
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_idx_q <= 5'h00;
            intv_cnt_q <= 8'h00;
        end else if (start_wave) begin
            step_idx_q <= 5'h00;
            intv_cnt_q <= wave_q[0][INTV_LSB +: INTV_W];
        end else if (step_end) begin
            if (!last_step) begin
                step_idx_q <= step_idx_q + 5'h01;
                intv_cnt_q <= wave_q[step_idx_q + 5'h01][INTV_LSB +: INTV_W];
            end
        end else if (busy && tick) begin
            intv_cnt_q <= intv_cnt_q - 8'h01;
        end
    end

    // New data is frozen for the whole wave; previous data starts at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            new_q <= '0;
            prev_q <= '0;
        end else begin
            if (start_wave) begin
                new_q <= {bp_data_q, seg_data_q};
            end
            if (finish) begin
                prev_q <= new_q;
            end
        end
    end

    // Per-electrode transition class: index 64 is the back plane
    for (genvar i = 0; i <= SEG_COUNT; i++) begin : g_lvl
        always_comb begin
            case ({prev_q[i], new_q[i]})
                2'b11: wave_lvl[i] = cur_step[BB_BIT];
                2'b10: wave_lvl[i] = cur_step[BW_BIT];
                2'b01: wave_lvl[i] = cur_step[WB_BIT];
                default: wave_lvl[i] = cur_step[WW_BIT];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, registered to keep the electrodes glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seg_out <= '0;
            seg_oe <= '0;
            bp_out <= 2'h0;
            bp_oe <= 2'h0;
            tp_out <= 2'h0;
            tp_oe <= 2'h0;
        end else if (busy) begin
            seg_out <= wave_lvl[SEG_COUNT-1:0];
            seg_oe <= {SEG_COUNT{~cur_step[HIZ_BIT]}};
            bp_out <= {2{wave_lvl[SEG_COUNT]}};
            bp_oe <= {2{~cur_step[HIZ_BIT]}};
            tp_out <= {2{cur_step[TP_LVL_BIT]}};
            tp_oe <= 2'h3;
        end else if (trig_ok && direct_q) begin
            seg_out <= seg_data_q;
            seg_oe <= {SEG_COUNT{~seg_hz_q}};
            bp_out <= {2{bp_data_q}};
            bp_oe <= {2{~seg_hz_q}};
            tp_out <= {2{tp_data_q}};
            tp_oe <= {2{~tp_hz_q}};
        end else if (!direct_q) begin
            seg_oe <= '0;
            bp_oe <= 2'h0;
            tp_oe <= 2'h0;
        end
    end

endmodule : epaper_waveform_generator

// ---- core/epd_wave_pkg.sv ----
package epd_wave_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] TCLK_CTRL_OFS = 8'h00;
    localparam logic [7:0] PANEL_CTRL_OFS = 8'h04;
    localparam logic [7:0] IRQ_CTRL_OFS = 8'h08;
    localparam logic [7:0] SEG_LO_OFS = 8'h10;
    localparam logic [7:0] SEG_HI_OFS = 8'h14;
    localparam logic [7:0] PLANE_DATA_OFS = 8'h18;
    localparam logic [7:0] WAVE_BASE_OFS = 8'h80;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int SRC_LSB = 0;
    localparam int DIV_LSB = 4;
    localparam int GATE_BIT = 8;
    localparam int TRIG_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int DIRECT_BIT = 4;
    localparam int DONE_BIT = 0;
    localparam int IRQEN_BIT = 8;
    localparam int BP_BIT = 0;
    localparam int TP_BIT = 1;
    localparam int SEGHZ_BIT = 2;
    localparam int TPHZ_BIT = 3;
    localparam int EOW_BIT = 15;
    localparam int HIZ_BIT = 13;
    localparam int TP_LVL_BIT = 12;
    localparam int BB_BIT = 11;
    localparam int BW_BIT = 10;
    localparam int WB_BIT = 9;
    localparam int WW_BIT = 8;
    localparam int INTV_LSB = 0;
    localparam int INTV_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Clock source codes
    localparam logic [1:0] SRC_FAST_B = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h1;
    localparam logic [1:0] SRC_FAST_A = 2'h2;
    localparam logic [3:0] FAST_SHIFT = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and sizes
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic GATE_RST = 1'b0;
    localparam logic DIRECT_RST = 1'b0;
    localparam logic [15:0] WAVE_RST = 16'h0000;
    localparam logic [15:0] STEP_MASK = 16'hbfff;
    localparam logic [4:0] LAST_STEP = 5'h1f;
    localparam int NUM_STEPS = 32;
    localparam int SEG_COUNT = 64;

    ////////////////////////////////////////////////////////////////////////
    // Bus responses and playback states
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_PLAY = 1'b1
    } play_state_type;

endpackage : epd_wave_pkg

// ---- core/tclk_divider.sv ----
`timescale 1ns/100ps
module tclk_divider
    import epd_wave_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Oscillator levels
    input wire logic fast_osc_a,
    input wire logic fast_osc_b,
    input wire logic slow_osc,
    // Settings
    input wire logic [1:0] source_sel,
    input wire logic [2:0] divide_sel,
    input wire logic gate_on,
    // One-cycle pulse per divided period
    output logic tick
);
    logic osc_lvl;
    logic osc_prev_q;
    logic osc_rise;
    logic [13:0] div_cnt_q;
    logic [13:0] div_last;
    logic tick_q;

    // Source selector; the reserved code yields no clock at all
    always_comb begin
        if (source_sel == SRC_FAST_B) begin
            osc_lvl = fast_osc_b;
        end else if (source_sel == SRC_SLOW) begin
            osc_lvl = slow_osc;
        end else if (source_sel == SRC_FAST_A) begin
            osc_lvl = fast_osc_a;
        end else begin
            osc_lvl = 1'b0;
        end
    end

    // Edge detect; oscillators must stay below half the bus clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_lvl;
        end
    end

    assign osc_rise = osc_lvl & ~osc_prev_q;

    // Terminal count: 2^n for slow, 128 * 2^n for fast sources
    always_comb begin
        if (source_sel == SRC_SLOW) begin
            div_last = (14'h1 << divide_sel) - 14'h1;
        end else begin
            div_last = (14'h1 << (divide_sel + FAST_SHIFT)) - 14'h1;
        end
    end

    // Divider and gate; gate off also restarts the count cleanly
    always_ff @(posedge aclk) begin
        if (!aresetn || !gate_on) begin
            div_cnt_q <= 14'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (osc_rise) begin
                if (div_cnt_q >= div_last) begin
                    div_cnt_q <= 14'h0;
                    tick_q <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 14'h1;
                end
            end
        end
    end

    assign tick = tick_q;

endmodule : tclk_divider

// ---- verification/wave_gen_sva.sv ----
`timescale 1ns/100ps
module wave_gen_sva (
    // Clock, reset and bus handshakes
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic rvalid,
    input wire logic rready,
    // Panel pins and status
    input wire logic [63:0] seg_oe,
    input wire logic [1:0] tp_out,
    input wire logic [1:0] tp_oe,
    input wire logic update_busy,
    input wire logic update_trigger_out,
    input wire logic divided_timing_clock
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    a_tp_pair: assert property (tp_out[0] == tp_out[1] && tp_oe[0] == tp_oe[1])
        else $error("top plane pins differ");
    a_trig_pulse: assert property (update_trigger_out |=> !update_trigger_out)
        else $error("trigger out longer than one cycle");
    a_trig_busy: assert property ($rose(update_busy) |-> ##[0:1] update_trigger_out)
        else $error("playback start without trigger out");
    // Pins float for a while once playback has ended
    a_float_end: assert property ($fell(update_busy) |-> ##1 (seg_oe == '0 && tp_oe == 2'h0) [*3])
        else $error("pins still driven after playback");
    a_tp_wave: assert property (update_busy && $past(update_busy) |-> tp_oe == 2'h3)
        else $error("top plane not driven in playback");
    a_tick_pulse: assert property (divided_timing_clock |=> !divided_timing_clock)
        else $error("timing tick too long");
    a_write_once: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    a_read_once: assert property (rvalid && rready |=> !rvalid)
        else $error("read data repeated");
endmodule : wave_gen_sva

bind epaper_waveform_generator wave_gen_sva chk_u (.*);

// ---- verification/panel_model.sv ----
`timescale 1ns/100ps
module panel_model (
    // Clock and segment electrodes
    input wire logic aclk,
    input wire logic [63:0] seg_out,
    input wire logic [63:0] seg_oe,
    // Level the panel sees
    output logic [63:0] seg_wire
);
    logic [63:0] last_q = '0;
    // No pull on the panel, so a floating pin flips each cycle instead of holding
    assign seg_wire = (seg_out & seg_oe) | (~last_q & ~seg_oe);
    always_ff @(posedge aclk) begin
        last_q <= seg_wire;
    end
endmodule : panel_model

// ---- verification/test_epaper_waveform_generator.sv ----
`timescale 1ns/100ps
module test_epaper_waveform_generator
    import epd_wave_pkg::*;
;
    localparam logic [15:0] W0 = 16'h1c01;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1, fast_osc_a = 1'b0, fast_osc_b = 1'b0, slow_osc = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, update_busy, update_done_irq;
    logic update_trigger_out, divided_timing_clock;
    logic [1:0] bresp, rresp, bp_out, bp_oe, tp_out, tp_oe;
    logic [1:0] br;
    logic [63:0] seg_out, seg_oe, seg_wire;
    int n_errors = 0, compares = 0, cyc = 0;
    epaper_waveform_generator dut_u (.*);
    panel_model panel_u (.aclk(aclk), .seg_out(seg_out), .seg_oe(seg_oe), .seg_wire(seg_wire));
    always #10 aclk = ~aclk;
    // Oscillators kept slow so every edge is sampled; timeout ceiling
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        slow_osc <= cyc[1];
        fast_osc_a <= cyc[2];
        fast_osc_b <= cyc[3];
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    task close_out;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta = 1'b0, tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            ta |= awready;
            tw |= wready;
        end
        do @(posedge aclk); while (!bvalid);
        br = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : rd
    // Cycles between two divided ticks after a new clock setting
    task automatic gap(input logic [31:0] cfg, output logic [31:0] p);
        wr(TCLK_CTRL_OFS, cfg);
        do @(posedge aclk); while (!divided_timing_clock);
        p = 0;
        do begin
            @(posedge aclk);
            p++;
        end while (!divided_timing_clock);
    endtask : gap
    // Expected level per pin from its previous and new data bits
    function automatic logic [31:0] lvl(input logic [31:0] p, n, input logic [15:0] w);
        for (int i = 0; i < 32; i++) lvl[i] = w[WW_BIT + {p[i], n[i]}];
    endfunction : lvl
    task automatic play(input logic [31:0] d, e, input logic ir);
        wr(SEG_LO_OFS, d);
        wr(PANEL_CTRL_OFS, 32'h1);
        repeat (4) @(posedge aclk);
        chk("seg", e, seg_out[31:0]);
        chk("oe", '1, seg_oe);
        chk("tp", {2{W0[TP_LVL_BIT]}}, tp_out);
        chk("bp", {2{W0[WW_BIT]}}, bp_out);
        wr(PANEL_CTRL_OFS, 32'h1);
        do @(posedge aclk); while (update_busy);
        repeat (2) @(posedge aclk);
        chk("busy", 1'b0, update_busy);
        chk("float", '0, seg_oe | bp_oe);
        chk("irq", ir, update_done_irq);
    endtask : play
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d1, v;
        logic [1:0] r;
        int n;
        void'($urandom(86));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(TCLK_CTRL_OFS, v, r);
        chk("tclk", '0, v);
        n = $urandom % 32;
        v = $urandom;
        wr(WAVE_BASE_OFS + 8'(4 * n), v);
        rd(WAVE_BASE_OFS + 8'(4 * n), d1, r);
        chk("step", v & STEP_MASK, d1);
        chk("bok", RESP_OKAY, br);
        rd(8'h40, v, r);
        chk("resp", RESP_SLVERR, r);
        wr(8'h40, v);
        chk("bresp", RESP_SLVERR, br);
        // Divided tick period from each source, then gated off
        n = $urandom % 3;
        gap((1 << GATE_BIT) | (n << DIV_LSB) | SRC_SLOW, v);
        chk("period", 4 << n, v);
        gap((1 << GATE_BIT) | SRC_FAST_A, v);
        chk("fast_a", 8 * 128, v);
        gap((1 << GATE_BIT) | SRC_FAST_B, v);
        chk("fast_b", 16 * 128, v);
        wr(TCLK_CTRL_OFS, 32'h21);
        repeat (2) @(posedge aclk);
        v = 0;
        repeat (40) @(posedge aclk) v += divided_timing_clock;
        chk("gated", '0, v);
        wr(TCLK_CTRL_OFS, 32'h121);
        wr(WAVE_BASE_OFS, W0);
        wr(WAVE_BASE_OFS + 8'h04, 32'ha000);
        wr(IRQ_CTRL_OFS, 32'h100);
        d1 = $urandom;
        play(d1, lvl('0, d1, W0), 1'b1);
        wr(IRQ_CTRL_OFS, 32'h101);
        chk("irq", 1'b0, update_done_irq);
        v = $urandom;
        play(v, lvl(d1, v, W0), 1'b1);
        wr(IRQ_CTRL_OFS, 32'h0);
        chk("mask", 1'b0, update_done_irq);
        wr(PANEL_CTRL_OFS, 32'h10);
        wr(PLANE_DATA_OFS, 32'h1);
        v = $urandom;
        wr(SEG_LO_OFS, v);
        wr(PANEL_CTRL_OFS, 32'h11);
        repeat (2) @(posedge aclk);
        chk("direct", v, seg_wire[31:0]);
        chk("planes", 4'hc, {bp_out, tp_out | ~tp_oe});
        close_out();
    end
endmodule : test_epaper_waveform_generator
